/* rtl/eth_axil_register_access.sv */
// AXI4-Lite register front end with config, status and statistics pages
`timescale 1ns/1ps
module eth_axil_register_access (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic STATS_SNAPSHOT_PULSE,
  input wire logic [eth_regs_pkg::NUM_STATS-1:0] STAT_EVENTS,
  input wire logic [31:0] TX_STATUS_EVENTS,
  input wire logic [31:0] RX_STATUS_EVENTS,
  input wire logic TX_RESET,
  input wire logic RX_RESET,
  output eth_regs_pkg::core_cfg_t CORE_CFG
);
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic [31:0] gt_reset_reg;
  logic [31:0] core_reset_reg;
  logic [31:0] mode_reg;
  logic [31:0] tx_cfg_reg;
  logic [31:0] rx_cfg_reg;
  logic [31:0] tx_status_reg;
  logic [31:0] rx_status_reg;
  logic [31:0] tx_status_next;
  logic [31:0] rx_status_next;
  logic [31:0] read_word;
  eth_regs_pkg::core_cfg_t cfg_reg;
  eth_regs_pkg::stat_bank_t held_stats;
  logic wr_fire;
  logic rd_fire;
  logic wr_ok;
  logic rd_ok;
  logic tick_access;
  logic snap_reg;
  logic unused_strobe;

  // Legal word addresses; shared by the read and the write path
  function automatic logic mapped(input logic [31:0] a, input logic wr);
    logic hit;
    hit = 1'b0;
    if (a[1:0] != 2'h0) begin
      hit = 1'b0;
    end else if (a == eth_regs_pkg::GT_RESET_ADDR ||
                 a == eth_regs_pkg::CORE_RESET_ADDR ||
                 a == eth_regs_pkg::MODE_ADDR ||
                 a == eth_regs_pkg::TX_CFG_ADDR ||
                 a == eth_regs_pkg::RX_CFG_ADDR ||
                 a == eth_regs_pkg::TICK_ADDR) begin
      hit = 1'b1;
    end else if (a == eth_regs_pkg::REVISION_ADDR ||
                 a == eth_regs_pkg::TX_STATUS_ADDR ||
                 a == eth_regs_pkg::RX_STATUS_ADDR) begin
      hit = !wr; // read-only
    end else if (a >= eth_regs_pkg::STATS_BASE &&
                 a < eth_regs_pkg::STATS_BASE +
                     32'(4 * eth_regs_pkg::NUM_STATS)) begin
      hit = !wr;
    end else begin
      hit = 1'b0;
    end
    return hit;
  endfunction

  // Strobes are ignored by design: whole-word writes only
  assign unused_strobe = ^S_AXI_WSTRB;

  // Handshake events
  assign wr_fire = awready_reg && S_AXI_AWVALID && S_AXI_WVALID;
  assign rd_fire = arready_reg && S_AXI_ARVALID;
  assign wr_ok = mapped(S_AXI_AWADDR, 1'b1);
  assign rd_ok = mapped(S_AXI_ARADDR, 1'b0);
  assign tick_access = (wr_fire && S_AXI_AWADDR == eth_regs_pkg::TICK_ADDR)
    || (rd_fire && S_AXI_ARADDR == eth_regs_pkg::TICK_ADDR);

  // Write channel: address and data taken together, one at a time
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= eth_regs_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_ok ? eth_regs_pkg::RESP_OKAY
                         : eth_regs_pkg::RESP_SLVERR;
    end else if (bvalid_reg) begin
      bvalid_reg <= !S_AXI_BREADY;
    end else begin
      awready_reg <= S_AXI_AWVALID && S_AXI_WVALID && !awready_reg;
      wready_reg <= S_AXI_AWVALID && S_AXI_WVALID && !awready_reg;
    end
  end

  // Read channel: data registered, reserved reads return zero
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= eth_regs_pkg::RESP_OKAY;
      rdata_reg <= eth_regs_pkg::ZERO_WORD;
    end else if (rd_fire) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_ok ? read_word : eth_regs_pkg::ZERO_WORD;
      rresp_reg <= rd_ok ? eth_regs_pkg::RESP_OKAY
                         : eth_regs_pkg::RESP_SLVERR;
    end else if (rvalid_reg) begin
      rvalid_reg <= !S_AXI_RREADY;
    end else begin
      arready_reg <= S_AXI_ARVALID && !arready_reg;
    end
  end

  // Read mux over the three pages
  always_comb begin
    read_word = eth_regs_pkg::ZERO_WORD;
    if (S_AXI_ARADDR == eth_regs_pkg::GT_RESET_ADDR) begin
      read_word = gt_reset_reg;
    end else if (S_AXI_ARADDR == eth_regs_pkg::CORE_RESET_ADDR) begin
      read_word = core_reset_reg;
    end else if (S_AXI_ARADDR == eth_regs_pkg::MODE_ADDR) begin
      read_word = mode_reg;
    end else if (S_AXI_ARADDR == eth_regs_pkg::TX_CFG_ADDR) begin
      read_word = tx_cfg_reg;
    end else if (S_AXI_ARADDR == eth_regs_pkg::RX_CFG_ADDR) begin
      read_word = rx_cfg_reg;
    end else if (S_AXI_ARADDR == eth_regs_pkg::REVISION_ADDR) begin
      read_word = eth_regs_pkg::REVISION_VALUE;
    end else if (S_AXI_ARADDR == eth_regs_pkg::TX_STATUS_ADDR) begin
      read_word = tx_status_reg;
    end else if (S_AXI_ARADDR == eth_regs_pkg::RX_STATUS_ADDR) begin
      read_word = rx_status_reg;
    end else if (S_AXI_ARADDR[31:8] == eth_regs_pkg::STATS_BASE[31:8]) begin
      read_word = held_stats[S_AXI_ARADDR[4:2]];
    end
  end

  // Software configuration registers, whole-word writes
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      gt_reset_reg <= eth_regs_pkg::GT_RESET_DEFAULT;
      core_reset_reg <= eth_regs_pkg::CORE_RESET_DEFAULT;
      mode_reg <= eth_regs_pkg::MODE_DEFAULT;
      tx_cfg_reg <= eth_regs_pkg::TX_CFG_DEFAULT;
      rx_cfg_reg <= eth_regs_pkg::RX_CFG_DEFAULT;
    end else if (wr_fire && wr_ok) begin
      if (S_AXI_AWADDR == eth_regs_pkg::GT_RESET_ADDR) begin
        gt_reset_reg <= S_AXI_WDATA;
      end else if (S_AXI_AWADDR == eth_regs_pkg::CORE_RESET_ADDR) begin
        core_reset_reg <= S_AXI_WDATA;
      end else if (S_AXI_AWADDR == eth_regs_pkg::MODE_ADDR) begin
        mode_reg <= S_AXI_WDATA;
      end else if (S_AXI_AWADDR == eth_regs_pkg::TX_CFG_ADDR) begin
        tx_cfg_reg <= S_AXI_WDATA;
      end else if (S_AXI_AWADDR == eth_regs_pkg::RX_CFG_ADDR) begin
        rx_cfg_reg <= S_AXI_WDATA;
      end
    end
  end

  // Core sees new settings only when software issues the core reset;
  // avoids retuning a running datapath half way through a frame
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      cfg_reg <= '{eth_regs_pkg::GT_RESET_DEFAULT, eth_regs_pkg::MODE_DEFAULT,
                   eth_regs_pkg::TX_CFG_DEFAULT,
                   eth_regs_pkg::RX_CFG_DEFAULT};
    end else if (core_reset_reg[eth_regs_pkg::APPLY_BIT]) begin
      cfg_reg <= '{gt_reset_reg, mode_reg, tx_cfg_reg, rx_cfg_reg};
    end
  end

  // Sticky status: set wins over the read clear
  always_comb begin
    tx_status_next = tx_status_reg;
    rx_status_next = rx_status_reg;
    if (rd_fire && S_AXI_ARADDR == eth_regs_pkg::TX_STATUS_ADDR) begin
      tx_status_next = eth_regs_pkg::ZERO_WORD;
    end
    if (rd_fire && S_AXI_ARADDR == eth_regs_pkg::RX_STATUS_ADDR) begin
      rx_status_next = eth_regs_pkg::ZERO_WORD;
    end
    tx_status_next = tx_status_next | TX_STATUS_EVENTS;
    rx_status_next = rx_status_next | RX_STATUS_EVENTS;
  end

  // Each datapath reset clears only its own direction
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      tx_status_reg <= eth_regs_pkg::ZERO_WORD;
      rx_status_reg <= eth_regs_pkg::ZERO_WORD;
    end else begin
      tx_status_reg <= TX_RESET ? eth_regs_pkg::ZERO_WORD
                                : tx_status_next;
      rx_status_reg <= RX_RESET ? eth_regs_pkg::ZERO_WORD
                                : rx_status_next;
    end
  end

  // Snapshot source picked by the mode select bit
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      snap_reg <= 1'b0;
    end else if (mode_reg[eth_regs_pkg::TICK_SEL_BIT]) begin
      snap_reg <= tick_access;
    end else begin
      snap_reg <= STATS_SNAPSHOT_PULSE;
    end
  end

  stats_snapshot u_stats (
    .clock(CLOCK),
    .reset(RESET),
    .events(STAT_EVENTS),
    .snap(snap_reg),
    .held(held_stats)
  );

  // Port drivers, all from flops
  assign S_AXI_AWREADY = awready_reg;
  assign S_AXI_WREADY = wready_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_ARREADY = arready_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RRESP = rresp_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign CORE_CFG = cfg_reg;

  // Checks on the slave behaviour
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  a_write_resp_next: assert property (
    wr_fire |=> S_AXI_BVALID && !S_AXI_AWREADY)
    else $error("write response not raised after handshake");
  a_resp_hold: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped before accept");
  a_reserved_read_err: assert property (
    rd_fire && !rd_ok |=> S_AXI_RVALID && S_AXI_RRESP == 2'h2
      && S_AXI_RDATA == 32'h0000_0000)
    else $error("reserved read not answered with error and zero");
  a_reserved_write_err: assert property (
    wr_fire && !wr_ok |=> S_AXI_BVALID && S_AXI_BRESP == 2'h2)
    else $error("reserved write not answered with error");
  a_full_word_write: assert property (
    wr_fire && S_AXI_AWADDR == eth_regs_pkg::TX_CFG_ADDR
      |=> tx_cfg_reg == $past(S_AXI_WDATA))
    else $error("full word not written");
  a_tick_reg_snap: assert property (
    mode_reg[30] && tick_access |=> snap_reg
      ##1 held_stats == $past(u_stats.live_reg))
    else $error("tick access did not snapshot counters");
  a_pulse_ignored_sel: assert property (
    mode_reg[30] && STATS_SNAPSHOT_PULSE && !tick_access |=> !snap_reg)
    else $error("pulse snapshot taken in register mode");
  a_pulse_snap: assert property (
    !mode_reg[30] && STATS_SNAPSHOT_PULSE |=> snap_reg)
    else $error("pulse snapshot missed");
  a_snapshot_stable: assert property (
    !snap_reg |=> $stable(held_stats))
    else $error("held counters changed without snapshot");
  a_status_clear: assert property (
    rd_fire && S_AXI_ARADDR == eth_regs_pkg::TX_STATUS_ADDR
      && TX_STATUS_EVENTS == 32'h0000_0000 |=> tx_status_reg == 32'h0000_0000)
    else $error("status not cleared by read");
  a_cfg_apply: assert property (
    !core_reset_reg[0] && !$past(core_reset_reg[0]) |-> $stable(CORE_CFG))
    else $error("core configuration changed without apply");

  c_tick_write: cover property (
    wr_fire && S_AXI_AWADDR == eth_regs_pkg::TICK_ADDR && mode_reg[30]);
  c_reserved_read: cover property (rd_fire && !rd_ok);
  c_status_clear: cover property (
    rd_fire && S_AXI_ARADDR == eth_regs_pkg::RX_STATUS_ADDR);
  c_pulse_snap: cover property (!mode_reg[30] && STATS_SNAPSHOT_PULSE);
endmodule

/* rtl/eth_regs_pkg.sv */
// Package: register map, field positions, reset values and carrier types
package eth_regs_pkg;
  localparam int DATA_W = 32;
  localparam int NUM_STATS = 8;
  // Page bases
  localparam logic [31:0] CFG_BASE = 32'h0000_0000;
  localparam logic [31:0] STATUS_BASE = 32'h0000_0400;
  localparam logic [31:0] STATS_BASE = 32'h0000_0500;
  // Configuration page registers
  localparam logic [31:0] GT_RESET_ADDR = 32'h0000_0000;
  localparam logic [31:0] CORE_RESET_ADDR = 32'h0000_0004;
  localparam logic [31:0] MODE_ADDR = 32'h0000_0008;
  localparam logic [31:0] TX_CFG_ADDR = 32'h0000_000C;
  localparam logic [31:0] RX_CFG_ADDR = 32'h0000_0014;
  localparam logic [31:0] TICK_ADDR = 32'h0000_0020;
  localparam logic [31:0] REVISION_ADDR = 32'h0000_0024;
  // Status page registers
  localparam logic [31:0] TX_STATUS_ADDR = 32'h0000_0400;
  localparam logic [31:0] RX_STATUS_ADDR = 32'h0000_0404;
  // Field positions
  localparam int TICK_SEL_BIT = 30;
  localparam int APPLY_BIT = 0;
  // Reset values
  localparam logic [31:0] GT_RESET_DEFAULT = 32'h0000_0000;
  localparam logic [31:0] CORE_RESET_DEFAULT = 32'h0000_0000;
  localparam logic [31:0] MODE_DEFAULT = 32'h0000_0000;
  localparam logic [31:0] TX_CFG_DEFAULT = 32'h0000_0000;
  localparam logic [31:0] RX_CFG_DEFAULT = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  // Arbitrary revision value, names no real part
  localparam logic [31:0] REVISION_VALUE = 32'h0000_0100;
  // Responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Configuration handed to the core
  typedef struct packed {
    logic [31:0] gt_reset;
    logic [31:0] mode;
    logic [31:0] tx_cfg;
    logic [31:0] rx_cfg;
  } core_cfg_t;

  typedef logic [NUM_STATS-1:0][31:0] stat_bank_t;
endpackage

/* rtl/stats_snapshot.sv */
// Statistics counters with snapshot-and-clear bank
`timescale 1ns/1ps
module stats_snapshot (
  input wire logic clock,
  input wire logic reset,
  input wire logic [eth_regs_pkg::NUM_STATS-1:0] events,
  input wire logic snap,
  output eth_regs_pkg::stat_bank_t held
);
  eth_regs_pkg::stat_bank_t live_reg;
  eth_regs_pkg::stat_bank_t held_reg;

  genvar i;
  generate
    for (i = 0; i < eth_regs_pkg::NUM_STATS; i = i + 1) begin : g_cnt
      // Event in the snapshot cycle starts the new interval, not lost
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          live_reg[i] <= eth_regs_pkg::ZERO_WORD;
        end else if (snap) begin
          live_reg[i] <= {31'h0000_0000, events[i]};
        end else begin
          live_reg[i] <= live_reg[i] + {31'h0000_0000, events[i]};
        end
      end

      // Held copy changes only on a snapshot, so reads never destroy it
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          held_reg[i] <= eth_regs_pkg::ZERO_WORD;
        end else if (snap) begin
          held_reg[i] <= live_reg[i];
        end
      end
    end
  endgenerate

  assign held = held_reg;
endmodule

/* tb/axil_master_model.sv */
// AXI4-Lite master model standing on the far side of the register port
`timescale 1ns/1ps
module axil_master_model (
  input wire logic clock,
  output logic [31:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [31:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  localparam int LIMIT = 40;

  // Idle bus at time zero
  initial begin
    {awaddr, wdata, wstrb, araddr} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
  end

  // Write: AW and W held together until the ready edge
  task automatic write(input logic [31:0] a, input logic [31:0] d,
      input logic [3:0] s, input int stall, output logic [1:0] resp);
    int n;
    @(posedge clock) #1;
    {awaddr, wdata, wstrb, awvalid, wvalid} = {a, d, s, 2'b11};
    for (n = 0; (awready & wready) !== 1'b1 && n < LIMIT; n++)
      @(posedge clock) #1;
    @(posedge clock) #1;
    // Released lines show inverted values so stale data never matches
    {awaddr, wdata, wstrb, awvalid, wvalid} = {~a, ~d, ~s, 2'b00};
    repeat (stall) @(posedge clock) #1;
    bready = 1'b1;
    for (n = 0; bvalid !== 1'b1 && n < LIMIT; n++) @(posedge clock) #1;
    // A hang hands back unknowns so the caller's comparison fails
    resp = (n < LIMIT) ? bresp : 2'bxx;
    @(posedge clock) #1;
    bready = 1'b0;
  endtask

  // Read: address held until the ready edge, data taken when valid is first seen, before the accept edge
  task automatic read(input logic [31:0] a, input int stall,
      output logic [31:0] data, output logic [1:0] resp);
    int n;
    @(posedge clock) #1;
    {araddr, arvalid} = {a, 1'b1};
    for (n = 0; arready !== 1'b1 && n < LIMIT; n++) @(posedge clock) #1;
    @(posedge clock) #1;
    {araddr, arvalid} = {~a, 1'b0};
    repeat (stall) @(posedge clock) #1;
    rready = 1'b1;
    for (n = 0; rvalid !== 1'b1 && n < LIMIT; n++) @(posedge clock) #1;
    data = (n < LIMIT) ? rdata : 'x;
    resp = (n < LIMIT) ? rresp : 2'bxx;
    @(posedge clock) #1;
    rready = 1'b0;
  endtask
endmodule

/* tb/eth_axil_register_access_tb_top.sv */
// Self-checking bench for the AXI4-Lite register front end
`timescale 1ns/1ps
module eth_axil_register_access_tb_top;
  localparam logic [1:0] OK = eth_regs_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = eth_regs_pkg::RESP_SLVERR;
  localparam int NS = eth_regs_pkg::NUM_STATS;
  localparam logic [31:0] CFG_ADDR[5] = '{eth_regs_pkg::GT_RESET_ADDR,
    eth_regs_pkg::CORE_RESET_ADDR, eth_regs_pkg::MODE_ADDR,
    eth_regs_pkg::TX_CFG_ADDR, eth_regs_pkg::RX_CFG_ADDR};
  // A hole, an unaligned word, past the last counter, beyond all pages
  localparam logic [31:0] BAD_ADDR[4] = '{32'h0000_0010, 32'h0000_0002,
    32'h0000_0520, 32'h0000_0600};
  localparam logic [31:0] TXS = eth_regs_pkg::TX_STATUS_ADDR;
  localparam logic [31:0] TICK = eth_regs_pkg::TICK_ADDR;
  logic clock;
  logic reset;
  logic [31:0] awaddr, wdata, araddr, rdata, tx_ev, rx_ev, data, tx_m, rx_m;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, snap_pulse, tx_rst, rx_rst;
  logic [NS-1:0] stat_ev;
  logic [127:0] applied;
  eth_regs_pkg::core_cfg_t core_cfg;
  logic [31:0] cfg_m[5];
  int live[NS];
  int held[NS];
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;

  eth_axil_register_access eth_axil_register_access_inst (
    .CLOCK(clock), .RESET(reset),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .STATS_SNAPSHOT_PULSE(snap_pulse), .STAT_EVENTS(stat_ev),
    .TX_STATUS_EVENTS(tx_ev), .RX_STATUS_EVENTS(rx_ev),
    .TX_RESET(tx_rst), .RX_RESET(rx_rst), .CORE_CFG(core_cfg)
  );
  axil_master_model axil_master_model_inst (
    .clock(clock), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready)
  );

  // Clock at 100 MHz, inside the host's allowed range
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Ceiling far above the twelve hundred or so cycles the run needs
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      close_out();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (fail_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Random strobes and stalls: strobes must not matter, stalls must wait
  task automatic wr(input logic [31:0] a, input logic [31:0] d,
      input logic [1:0] er);
    axil_master_model_inst.write(a, d, 4'($urandom), $urandom_range(3),
      resp);
    check({30'h0, resp}, {30'h0, er});
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp,
      input logic [1:0] er);
    axil_master_model_inst.read(a, $urandom_range(3), data, resp);
    check(data, exp);
    check({30'h0, resp}, {30'h0, er});
  endtask
  // Every implemented register but the tick address against the model; status clears on read
  task automatic check_all();
    for (int i = 0; i < 5; i++) rd(CFG_ADDR[i], cfg_m[i], OK);
    rd(eth_regs_pkg::REVISION_ADDR, eth_regs_pkg::REVISION_VALUE,
      OK);
    rd(TXS, tx_m, OK);
    rd(eth_regs_pkg::RX_STATUS_ADDR, rx_m, OK);
    {tx_m, rx_m} = '0;
    for (int i = 0; i < NS; i++)
      rd(eth_regs_pkg::STATS_BASE + 32'(4 * i), 32'(held[i]), OK);
  endtask
  task automatic check_cfg();
    for (int i = 0; i < 4; i++)
      check(core_cfg[32*i +: 32], applied[32*i +: 32]);
  endtask
  // Model snapshot once the design's two-cycle transfer has landed
  task automatic snap_model();
    repeat (3) @(posedge clock) #1;
    held = live;
    live = '{default: 0};
  endtask
  // Events stop before any snapshot so no count straddles it
  task automatic run_events(input int n);
    repeat (n) begin
      stat_ev = NS'($urandom);
      for (int i = 0; i < NS; i++) live[i] += int'(stat_ev[i]);
      @(posedge clock) #1;
    end
    stat_ev = '0;
    @(posedge clock) #1;
  endtask
  task automatic status_events();
    {tx_ev, rx_ev} = {$urandom, $urandom};
    {tx_m, rx_m} = {tx_m | tx_ev, rx_m | rx_ev};
    @(posedge clock) #1;
    {tx_ev, rx_ev} = '0;
    @(posedge clock) #1;
  endtask

  initial begin
    {reset, snap_pulse, tx_rst, rx_rst} = 4'b1000;
    {tx_ev, rx_ev, stat_ev, tx_m, rx_m, applied} = '0;
    cfg_m = '{default: '0};
    live = '{default: 0};
    held = '{default: 0};
    void'($urandom(62));
    repeat (5) @(posedge clock);
    #1;
    reset = 1'b0;
    // Defaults, then reserved, unaligned and read-only places
    check_all();
    check_cfg();
    foreach (BAD_ADDR[i]) begin
      rd(BAD_ADDR[i], '0, ERR);
      wr(BAD_ADDR[i], $urandom, ERR);
    end
    wr(eth_regs_pkg::REVISION_ADDR, $urandom, ERR);
    wr(TXS, $urandom, ERR);
    wr(eth_regs_pkg::STATS_BASE, $urandom, ERR);
    // Random words; apply and tick-select bits held low for now
    for (int i = 0; i < 5; i++) begin
      cfg_m[i] = $urandom & 32'hBFFF_FFFE;
      wr(CFG_ADDR[i], cfg_m[i], OK);
    end
    check_all();
    check_cfg();
    cfg_m[1] = cfg_m[1] | 32'h0000_0001;
    wr(CFG_ADDR[1], cfg_m[1], OK);
    applied = {cfg_m[0], cfg_m[2], cfg_m[3], cfg_m[4]};
    @(posedge clock) #1;
    check_cfg();
    cfg_m[1] = 32'h0000_0000;
    wr(CFG_ADDR[1], cfg_m[1], OK);
    cfg_m[3] = ~cfg_m[3];
    wr(CFG_ADDR[3], cfg_m[3], OK);
    check_cfg();
    // Sticky status, cleared by read and by each side's own reset
    status_events();
    rd(TXS, tx_m, OK);
    tx_m = '0;
    status_events();
    tx_rst = 1'b1;
    @(posedge clock) #1;
    {tx_rst, tx_m} = '0;
    check_all();
    status_events();
    rx_rst = 1'b1;
    @(posedge clock) #1;
    {rx_rst, rx_m} = '0;
    check_all();
    // Pulse-driven snapshot while tick select is low, read twice
    run_events(40);
    snap_pulse = 1'b1;
    @(posedge clock) #1;
    snap_pulse = 1'b0;
    snap_model();
    check_all();
    check_all();
    // Tick select high: pulse ignored, tick read and write snapshot
    cfg_m[2] = cfg_m[2] | 32'h4000_0000;
    wr(CFG_ADDR[2], cfg_m[2], OK);
    run_events(30);
    snap_pulse = 1'b1;
    @(posedge clock) #1;
    snap_pulse = 1'b0;
    repeat (3) @(posedge clock) #1;
    check_all();
    rd(TICK, '0, OK);
    snap_model();
    check_all();
    run_events(25);
    wr(TICK, $urandom, OK);
    snap_model();
    check_all();
    // Second reset in mid-run with status pending
    status_events();
    reset = 1'b1;
    repeat (2) @(posedge clock) #1;
    reset = 1'b0;
    cfg_m = '{default: '0};
    {tx_m, rx_m, applied} = '0;
    held = '{default: 0};
    live = '{default: 0};
    check_all();
    check_cfg();
    close_out();
  end
endmodule
